// ---- hdl/nplc_counter.v ----
`timescale 1ns/10ps
`include "nplc_defines.vh"

// Notes on behaviour
// [R1] mode decides accumulation every clock cycle
// [R2] own pll synthesises output frequencies
// [R3] new control mode applies at once; the pll starts and stops from the registered mode, one cycle later
// [R4] mode zero: no accumulation, no pin drive
// [R5] control fields: mode, divider, two pins
// [R6] five bit mode picks accumulate and outputs
// [R7] divider code 0 is /128, 7 is /1
// [R8] pll modes accumulate; top bit is reference
// [R9] vco runs at sixteen times reference
// [R10] software keeps vco within recommended range
// [R11] mode 1 no pins; mode 2 primary pin
// [R12] addend register writable at any time
// [R13] accumulator readable, writable and free running
// [R14] accumulator write overrides that cycle's sum
// [R15] live accumulator only as source operand
// [R16] destination read returns last written value
// [R17] outputs ored with core, gated by direction
// [R18] all registers clear at core start
// [R19] accumulation wraps modulo two to the 32

// ------------------------------------------------------------------
// one counter module of a processor core
// ------------------------------------------------------------------
module nplc_counter #(
    parameter DATA_W = 32,
    parameter PIN_N  = 32,
    parameter DIV_W  = 7
) (
    input  wire              core_clk_i,
    input  wire              rstn_i,
    // core register port
    input  wire              wr_ctrl_i,
    input  wire              wr_addend_i,
    input  wire              wr_accum_i,
    input  wire [DATA_W-1:0] wr_data_i,
    input  wire              rd_en_i,
    input  wire [1:0]        rd_sel_i,
    input  wire              rd_src_i,
    output reg  [DATA_W-1:0] rd_data_o,
    // core i/o merge
    input  wire [PIN_N-1:0]  core_out_i,
    input  wire [PIN_N-1:0]  core_dir_i,
    input  wire [PIN_N-1:0]  chain_out_i,
    input  wire [PIN_N-1:0]  chain_dir_i,
    output reg  [PIN_N-1:0]  pin_out_o,
    output reg  [PIN_N-1:0]  pin_dir_o,
    // status
    output reg  [4:0]        mode_o,
    output reg               pll_out_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // single pin mask with a level on the selected pin
    function [PIN_N-1:0] pin_mask;
        input [5:0] sel;
        input       lvl;
        integer     k;
        begin
            pin_mask = {PIN_N{1'b0}};
            for (k = 0; k < PIN_N; k = k + 1) begin
                if (k[5:0] == sel) begin
                    pin_mask[k] = lvl;
                end
            end
        end
    endfunction

    // mode field out of a control word
    function [4:0] mode_of;
        input [DATA_W-1:0] word;
        begin
            mode_of = word[`NPLC_MODE_HI:`NPLC_MODE_LO];          // [R5]
        end
    endfunction

    // accumulate decision for one mode
    function acc_of;
        input [4:0] mode;
        begin
            case (mode)
                `NPLC_MODE_PLL_INT: acc_of = 1'b1;                // [R8]
                `NPLC_MODE_PLL_SE:  acc_of = 1'b1;
                `NPLC_MODE_PLL_DF:  acc_of = 1'b1;
                default:            acc_of = 1'b0;                // [R4]
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [DATA_W-1:0] ctrl_q;
    reg  [DATA_W-1:0] ctrl_d;
    reg  [DATA_W-1:0] addend_q;
    reg  [DATA_W-1:0] addend_d;
    reg  [DATA_W-1:0] accum_q;
    reg  [DATA_W-1:0] accum_d;
    reg  [DATA_W-1:0] shadow_q;
    reg  [DATA_W-1:0] shadow_d;
    reg  [DATA_W-1:0] rd_data_d;
    reg  [PIN_N-1:0]  pin_out_d;
    reg  [PIN_N-1:0]  pin_dir_d;
    reg  [PIN_N-1:0]  cnt_pins;

    wire [4:0]        mode_now;
    wire [4:0]        mode_reg;
    wire              acc_now;
    wire [2:0]        tap_sel;
    wire [5:0]        primary_pin_select_sel;
    wire [5:0]        secondary_pin_select_sel;
    wire              pll_run;
    wire              pll_sig;
    wire [DATA_W-1:0] sum_w;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------

    // a control write steers accumulation in its own cycle, so the
    // new mode has no one-cycle lag behind the instruction
    assign mode_now = wr_ctrl_i ? mode_of(wr_data_i)
                                : mode_of(ctrl_q);                // [R3]
    assign mode_reg = mode_of(ctrl_q);
    assign acc_now  = acc_of(mode_now);                           // [R1]
    assign tap_sel  = ctrl_q[`NPLC_DIV_HI:`NPLC_DIV_LO];          // [R5]
    assign primary_pin_select_sel = ctrl_q[`NPLC_PRIMARY_PIN_SELECT_HI:`NPLC_PRIMARY_PIN_SELECT_LO];
    assign secondary_pin_select_sel = ctrl_q[`NPLC_SECONDARY_PIN_SELECT_HI:`NPLC_SECONDARY_PIN_SELECT_LO];

    // carry out of the top bit is dropped by the width
    assign sum_w    = accum_q + addend_q;                         // [R19]

    // ------------------------------------------------------------------
    // control and addend next state
    // ------------------------------------------------------------------

    // both take a write whenever the core issues one
    always @* begin
        ctrl_d   = ctrl_q;
        addend_d = addend_q;
        if (wr_ctrl_i) begin
            ctrl_d = wr_data_i;                                   // [R3]
        end
        if (wr_addend_i) begin
            addend_d = wr_data_i;                                 // [R12]
        end
    end

    // ------------------------------------------------------------------
    // accumulator next state
    // ------------------------------------------------------------------

    // a write beats the sum; the shadow remembers the written value
    // for read-modify-write destination fetches
    always @* begin
        accum_d  = accum_q;
        shadow_d = shadow_q;
        if (wr_accum_i) begin
            accum_d  = wr_data_i;                                 // [R14]
            shadow_d = wr_data_i;                                 // [R16]
        end else if (acc_now) begin
            accum_d  = sum_w;                                     // [R13]
        end
    end

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------

    // only a source fetch sees the live accumulator; a destination
    // fetch gets the shadow, like the core's other special registers
    always @* begin
        rd_data_d = rd_data_o;
        if (rd_en_i) begin
            case (rd_sel_i)
                `NPLC_SEL_CTRL:   rd_data_d = ctrl_q;
                `NPLC_SEL_ADDEND: rd_data_d = addend_q;
                `NPLC_SEL_ACCUM: begin
                    if (rd_src_i) begin
                        rd_data_d = accum_q;                      // [R15]
                    end else begin
                        rd_data_d = shadow_q;                     // [R16]
                    end
                end
                default:          rd_data_d = {DATA_W{1'b0}};
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pll
    // ------------------------------------------------------------------

    // the pll only runs in the pll modes; elsewhere it is held reset
    assign pll_run = acc_of(mode_reg);                            // [R8]

    nplc_pll #(
        .ACC_W (DATA_W),
        .DIV_W (DIV_W)
    ) u_pll (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .run_i      (pll_run),
        .addend_i   (addend_q),
        .tap_i      (tap_sel),
        .pll_o      (pll_sig)
    );                                                            // [R2]

    // ------------------------------------------------------------------
    // counter pin functions
    // ------------------------------------------------------------------

    // primary and secondary levels per mode; the mode is reread from
    // the written word so a zero write stops output at once
    always @* begin
        cnt_pins = {PIN_N{1'b0}};
        case (mode_now)                                           // [R6]
            `NPLC_MODE_PLL_SE: begin
                cnt_pins = pin_mask(primary_pin_select_sel, pll_sig);           // [R11]
            end
            `NPLC_MODE_PLL_DF: begin
                cnt_pins = pin_mask(primary_pin_select_sel, pll_sig)
                         | pin_mask(secondary_pin_select_sel, ~pll_sig);
            end
            `NPLC_MODE_PLL_INT: begin
                cnt_pins = {PIN_N{1'b0}};                         // [R11]
            end
            default: begin
                cnt_pins = {PIN_N{1'b0}};                         // [R4]
            end
        endcase
    end

    // ------------------------------------------------------------------
    // merge with core i/o
    // ------------------------------------------------------------------

    // core direction gates everything before the cross-core or, so
    // no core can fight another on a pin
    always @* begin
        pin_out_d = ((cnt_pins | core_out_i) & core_dir_i)
                  | chain_out_i;                                  // [R17]
        pin_dir_d = core_dir_i | chain_dir_i;                     // [R17]
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------

    // core start clears all four registers, leaving the counter off
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q   <= `NPLC_CTRL_RST;                           // [R18]
            addend_q <= `NPLC_ADDEND_RST;
            accum_q  <= `NPLC_ACCUM_RST;
            shadow_q <= `NPLC_ACCUM_RST;
        end else begin
            ctrl_q   <= ctrl_d;
            addend_q <= addend_d;
            accum_q  <= accum_d;
            shadow_q <= shadow_d;
        end
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------

    // every output comes from a flop; pins lag the logic by a cycle
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= {DATA_W{1'b0}};
            pin_out_o <= {PIN_N{1'b0}};
            pin_dir_o <= {PIN_N{1'b0}};
            mode_o    <= `NPLC_MODE_OFF;
            pll_out_o <= 1'b0;
        end else begin
            rd_data_o <= rd_data_d;
            pin_out_o <= pin_out_d;
            pin_dir_o <= pin_dir_d;
            mode_o    <= mode_now;
            pll_out_o <= pll_sig;
        end
    end

endmodule // nplc_counter

// ---- hdl/nplc_defines.vh ----
`ifndef NPLC_DEFINES_VH
`define NPLC_DEFINES_VH

// ------------------------------------------------------------------
// control register field positions
// ------------------------------------------------------------------
`define NPLC_MODE_HI      30
`define NPLC_MODE_LO      26
`define NPLC_DIV_HI       25
`define NPLC_DIV_LO       23
`define NPLC_SECONDARY_PIN_SELECT_HI      14
`define NPLC_SECONDARY_PIN_SELECT_LO      9
`define NPLC_PRIMARY_PIN_SELECT_HI      5
`define NPLC_PRIMARY_PIN_SELECT_LO      0

// ------------------------------------------------------------------
// mode codes handled by this block
// ------------------------------------------------------------------
`define NPLC_MODE_OFF     5'h00
`define NPLC_MODE_PLL_INT 5'h01
`define NPLC_MODE_PLL_SE  5'h02
`define NPLC_MODE_PLL_DF  5'h03

// ------------------------------------------------------------------
// register select codes on the core register port
// ------------------------------------------------------------------
`define NPLC_SEL_CTRL     2'h0
`define NPLC_SEL_ADDEND   2'h1
`define NPLC_SEL_ACCUM    2'h2

// ------------------------------------------------------------------
// reset values and pll figures
// ------------------------------------------------------------------
`define NPLC_CTRL_RST     32'h00000000
`define NPLC_ADDEND_RST   32'h00000000
`define NPLC_ACCUM_RST    32'h00000000
`define NPLC_VCO_SHIFT    4
`define NPLC_TAP_MAX      3'h7
`define NPLC_VCO_MAX_MHZ  128
`define NPLC_CLK_MHZ      125

`endif

// ---- hdl/nplc_pll.v ----
`timescale 1ns/10ps
`include "nplc_defines.vh"

// ------------------------------------------------------------------
// digital pll stand-in: vco tracks sixteen times the reference
// accumulator rate, then a power-of-two tap divides it down
// ------------------------------------------------------------------
module nplc_pll #(
    parameter ACC_W = 32,
    parameter DIV_W = 7
) (
    input  wire             core_clk_i,
    input  wire             rstn_i,
    input  wire             run_i,
    input  wire [ACC_W-1:0] addend_i,
    input  wire [2:0]       tap_i,
    output reg              pll_o
);

    localparam VCO_W = ACC_W + DIV_W;

    reg  [VCO_W-1:0] vco_q;
    wire [VCO_W-1:0] step_w;
    wire [VCO_W-1:0] vco_d;
    wire [2:0]       shift_w;

    // vco runs 16x faster than the reference bit of the accumulator
    assign step_w  = {{DIV_W{1'b0}}, addend_i} << `NPLC_VCO_SHIFT; // [R9]
    assign vco_d   = vco_q + step_w;
    // tap 7 is divide by 1, tap 0 divide by 128
    assign shift_w = `NPLC_TAP_MAX - tap_i;                       // [R7]

    // ------------------------------------------------------------------
    // vco phase and divided output
    // ------------------------------------------------------------------
    // limitation: output above half the clock rate aliases, a real
    // analog loop would be needed to reach the top of the vco range
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vco_q <= {VCO_W{1'b0}};
            pll_o <= 1'b0;
        end else if (run_i) begin
            vco_q <= vco_d;                                       // [R2]
            pll_o <= vco_d[ACC_W-1+shift_w];
        end else begin
            vco_q <= {VCO_W{1'b0}};
            pll_o <= 1'b0;
        end
    end

endmodule // nplc_pll

// ---- verif/nplc_counter_props.sv ----
`timescale 1ns/10ps
// ----
// port checker for one counter module
// ----
module nplc_counter_chk (
    input wire        core_clk_i,
    input wire        rstn_i,
    input wire        wr_ctrl_i,
    input wire        wr_addend_i,
    input wire        wr_accum_i,
    input wire [31:0] wr_data_i,
    input wire        rd_en_i,
    input wire [1:0]  rd_sel_i,
    input wire        rd_src_i,
    input wire [31:0] rd_data_o,
    input wire [31:0] core_out_i,
    input wire [31:0] core_dir_i,
    input wire [31:0] chain_out_i,
    input wire [31:0] chain_dir_i,
    input wire [31:0] pin_out_o,
    input wire [31:0] pin_dir_o,
    input wire [4:0]  mode_o,
    input wire        pll_out_o
);
    reg  [31:0] ctrl_q;
    reg  [31:0] add_q;
    reg  [31:0] acc_q;
    reg  [31:0] last_q;
    wire [4:0]  eff_mode;
    wire        acc_on;

    // control write data steers this very cycle
    assign eff_mode = wr_ctrl_i ? wr_data_i[30:26] : ctrl_q[30:26];
    assign acc_on   = (eff_mode != 5'h00) && (eff_mode < 5'h04);

    // shadow registers; a write wins over the sum, carry out is lost
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= 32'h00000000;
            add_q  <= 32'h00000000;
            acc_q  <= 32'h00000000;
            last_q <= 32'h00000000;
        end else begin
            ctrl_q <= wr_ctrl_i ? wr_data_i : ctrl_q;
            add_q  <= wr_addend_i ? wr_data_i : add_q;
            last_q <= wr_accum_i ? wr_data_i : last_q;
            acc_q  <= wr_accum_i ? wr_data_i :
                      acc_on ? acc_q + add_q : acc_q;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    mode_now_a: assert property (
        1'b1 |=> mode_o == $past(eff_mode))
        else $error("mode output lags the written mode");
    rd_live_a: assert property (
        rd_en_i && rd_sel_i == 2'h2 && rd_src_i |=> rd_data_o == $past(acc_q))
        else $error("live accumulator read wrong");
    rd_dest_a: assert property (
        rd_en_i && rd_sel_i == 2'h2 && !rd_src_i |=>
        rd_data_o == $past(last_q))
        else $error("destination read is not the last write");
    rd_ctrl_a: assert property (
        rd_en_i && rd_sel_i == 2'h0 |=> rd_data_o == $past(ctrl_q))
        else $error("control read wrong");
    rd_addend_a: assert property (
        rd_en_i && rd_sel_i == 2'h1 |=> rd_data_o == $past(add_q))
        else $error("addend read wrong");
    rd_none_a: assert property (
        rd_en_i && rd_sel_i == 2'h3 |=> rd_data_o == 32'h00000000)
        else $error("unused select returned data");
    rd_hold_a: assert property (
        !rd_en_i |=> $stable(rd_data_o))
        else $error("read data moved without a read");
    pin_off_a: assert property (
        mode_o < 5'h02 || mode_o > 5'h03 |->
        pin_out_o == $past((core_out_i & core_dir_i) | chain_out_i))
        else $error("counter drove a pin while not driving");
    pin_dir_a: assert property (
        1'b1 |=> pin_dir_o == $past(core_dir_i | chain_dir_i))
        else $error("pin direction merge wrong");
    pll_off_a: assert property (
        mode_o == 5'h00 && $past(mode_o) == 5'h00 &&
        $past(mode_o, 2) == 5'h00 && $past(mode_o, 3) == 5'h00 |-> !pll_out_o)
        else $error("pll output alive with counter off");
endmodule // nplc_counter_chk

bind nplc_counter nplc_counter_chk u_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wr_ctrl_i(wr_ctrl_i),
    .wr_addend_i(wr_addend_i), .wr_accum_i(wr_accum_i),
    .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_sel_i(rd_sel_i),
    .rd_src_i(rd_src_i), .rd_data_o(rd_data_o), .core_out_i(core_out_i),
    .core_dir_i(core_dir_i), .chain_out_i(chain_out_i),
    .chain_dir_i(chain_dir_i), .pin_out_o(pin_out_o),
    .pin_dir_o(pin_dir_o), .mode_o(mode_o), .pll_out_o(pll_out_o));

// ---- verif/nplc_core_io.sv ----
`timescale 1ns/10ps
// ----
// owning core i/o side: output and direction registers of the core
// and the or of earlier cores
// ----
module nplc_core_io (
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire        ld_i,
    input  wire [31:0] out_i,
    input  wire [31:0] dir_i,
    input  wire [31:0] chain_i,
    output reg  [31:0] core_out_o,
    output reg  [31:0] core_dir_o,
    output reg  [31:0] chain_out_o,
    output reg  [31:0] chain_dir_o
);
    // cleared at start so a stopped core leaves the pins alone
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_out_o  <= 32'h00000000;
            core_dir_o  <= 32'h00000000;
            chain_out_o <= 32'h00000000;
            chain_dir_o <= 32'h00000000;
        end else if (ld_i) begin
            core_out_o  <= out_i;
            core_dir_o  <= dir_i;
            chain_out_o <= chain_i;
            chain_dir_o <= chain_i; // earlier cores own what they drive
        end
    end
endmodule // nplc_core_io

// ---- verif/nplc_counter_tb_top.sv ----
`timescale 1ns/10ps
// ----
// bench for one counter module beside its core i/o side
// ----
module nplc_counter_tb_top;
    logic        clk, rstn, ld, wr_c, wr_f, wr_p, rd_en, rd_src, pll;
    logic        p_pll, p_pin;
    logic [1:0]  rd_sel;
    logic [4:0]  mode;
    logic [15:0] r;
    logic [31:0] wdata, rdata, io_out, io_dir, io_chain, v1, v2;
    logic [31:0] c_out, c_dir, h_out, h_dir, pin_out, pin_dir;
    int          err_total, cmp_count, cyc, n_pll, n_pin, n_bad;
    // rows: mode, divider code, pll toggles in 480 cycles
    localparam logic [15:0] ROWS [6] = '{16'h0807, 16'h1007, 16'h133D,
        16'h1807, 16'h1B3D, 16'h0000};
    // reference near 8 MHz keeps the vco in its stable band
    localparam logic [31:0] FREQ = 32'h10624DD3;

    nplc_counter i_dut (
        .core_clk_i(clk), .rstn_i(rstn), .wr_ctrl_i(wr_c),
        .wr_addend_i(wr_f), .wr_accum_i(wr_p), .wr_data_i(wdata),
        .rd_en_i(rd_en), .rd_sel_i(rd_sel), .rd_src_i(rd_src),
        .rd_data_o(rdata), .core_out_i(c_out), .core_dir_i(c_dir),
        .chain_out_i(h_out), .chain_dir_i(h_dir), .pin_out_o(pin_out),
        .pin_dir_o(pin_dir), .mode_o(mode), .pll_out_o(pll));
    nplc_core_io u_io (
        .core_clk_i(clk), .rstn_i(rstn), .ld_i(ld), .out_i(io_out),
        .dir_i(io_dir), .chain_i(io_chain), .core_out_o(c_out),
        .core_dir_o(c_dir), .chain_out_o(h_out), .chain_dir_o(h_dir));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // strobes drop then one idle cycle, so calls never collide
    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        {wr_c, wr_f, wr_p} = s;
        wdata = d;
        @(negedge clk);
        {wr_c, wr_f, wr_p} = 3'h0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [1:0] s, input logic src,
                      output logic [31:0] v);
        rd_en = 1'b1;
        rd_sel = s;
        rd_src = src;
        @(negedge clk);
        rd_en = 1'b0;
        v = rdata;
        @(negedge clk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, well above the few thousand cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end

    initial begin
        {rstn, ld, wr_c, wr_f, wr_p, rd_en, rd_src} = 7'h00;
        rd_sel = 2'h0;
        wdata = 32'h0;
        {io_out, io_dir, io_chain} = 96'h0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(i[1:0], 1'b0, v1);
            check(v1, 32'h0);
        end
        rd(2'h2, 1'b1, v1);
        check(v1, 32'h0);
        // core merge: output gated by direction, then or with chain
        {io_out, io_dir, io_chain} = {32'hF0F0F0F0, 32'h00FF00FF, 32'h3};
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        repeat (2) @(negedge clk);
        check(pin_out, 32'h00F000F3);
        check(pin_dir, 32'h00FF00FF);
        $display("test reset and merge done");
        // mode write counts from its own cycle; sum wraps past 2^32
        wr(3'h2, 32'hF0000001);
        wr(3'h1, 32'h12345678);
        wr(3'h4, 32'h04000000);
        repeat (2) @(negedge clk);
        rd(2'h2, 1'b1, v1);
        check(v1, 32'h12345678 + 32'h4 * 32'hF0000001);
        wr(3'h1, 32'h00000010);
        rd(2'h2, 1'b1, v1);
        check(v1, 32'h00000010 + 32'hF0000001);
        rd(2'h2, 1'b0, v1);
        check(v1, 32'h00000010);
        rd(2'h0, 1'b0, v1);
        check(v1, 32'h04000000);
        rd(2'h1, 1'b0, v1);
        check(v1, 32'hF0000001);
        wr(3'h4, 32'h0);
        rd(2'h2, 1'b1, v1);
        // nine sums land between the write of 0x10 and the off write
        check(v1, 32'h00000010 + 32'h9 * 32'hF0000001);
        rd(2'h2, 1'b1, v2);
        check(v2, v1);
        $display("test accumulator done");
        // pll rows with every pin an output, primary 5, secondary 9
        {io_out, io_dir, io_chain} = {32'h0, 32'hFFFFFFFF, 32'h0};
        wr(3'h2, FREQ);
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        for (int i = 0; i < 6; i++) begin
            r = ROWS[i];
            wr(3'h4, {1'b0, r[15:8], 8'h00, 6'h09, 3'h0, 6'h05});
            n_pll = 0;
            n_pin = 0;
            n_bad = 0;
            p_pll = pll;
            p_pin = pin_out[5];
            for (int k = 0; k < 480; k++) begin
                @(negedge clk);
                n_pll += (pll !== p_pll);
                n_pin += (pin_out[5] !== p_pin);
                p_pll = pll;
                p_pin = pin_out[5];
                if (r[15:11] == 5'h03)
                    n_bad += (k > 4 && pin_out[9] === pin_out[5]);
                else
                    n_bad += (pin_out[9] !== 1'b0);
                n_bad += ((pin_out & 32'hFFFFFDDF) !== 32'h0);
            end
            check(32'(n_pll), {24'h0, r[7:0]});
            check(32'(n_pin), r[15:12] == 4'h1 ? {24'h0, r[7:0]} : 0);
            check(32'(n_bad), 32'h0);
            check({27'h0, mode}, {27'h0, r[15:11]});
            wr(3'h4, 32'h0);
            repeat (4) @(negedge clk);
        end
        $display("test pll rows done");
        // reset in mid-run clears outputs and registers
        wr(3'h4, 32'h08000000);
        rstn = 1'b0;
        @(negedge clk);
        check(rdata, 32'h0);
        check({26'h0, mode, pll}, 32'h0);
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        rd(2'h0, 1'b0, v1);
        check(v1, 32'h0);
        $display("test mid-run reset done");
        stop_test;
    end
endmodule // nplc_counter_tb_top
